//--- pkg/fnet_defs.svh
`ifndef FNET_DEFS_SVH
`define FNET_DEFS_SVH

// ****************************************
// Register offsets
// ****************************************
`define FNET_ADDR_W        5
`define FNET_OFS_REF_RATIO 5'h02
`define FNET_OFS_INT_WORD  5'h03
`define FNET_OFS_FRAC_WORD 5'h04
`define FNET_OFS_STEP_CNT  5'h0C

// ****************************************
// Field widths
// ****************************************
`define FNET_REF_W         14
`define FNET_INT_W         19
`define FNET_FRAC_W        24
`define FNET_STEP_W        14
`define FNET_DATA_W        24

// ****************************************
// Reset values
// ****************************************
`define FNET_REF_RST       14'h0001
`define FNET_INT_RST       19'h00014
`define FNET_FRAC_RST      24'h000000
`define FNET_STEP_RST      14'h0000

`endif

//--- pkg/fnet_pkg.sv
package fnet_pkg;

	typedef enum logic [1:0] {
		FNET_MODE_INT   = 2'b00,
		FNET_MODE_FRAC  = 2'b01,
		FNET_MODE_EXACT = 2'b10
	} fnet_mode_t;

endpackage

//--- hw/fnet_ref_div.sv
`timescale 1ns/1ps
`include "fnet_defs.svh"

module fnet_ref_div (
	input  wire logic                   core_clk,
	input  wire logic                   rst_n,
	input  wire logic [`FNET_REF_W-1:0] ref_ratio,
	output logic                        pd_tick
);

	logic [`FNET_REF_W-1:0] count;
	wire                    last_count;

	// Ratio of zero behaves as one
	assign last_count = (count >= ref_ratio - `FNET_REF_W'(1)) ||
		(ref_ratio == '0);

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			count   <= '0;
			pd_tick <= 1'b0;
		end else begin
			count   <= last_count ? '0 : count + `FNET_REF_W'(1);
			pd_tick <= last_count;
		end
	end

endmodule

//--- hw/fnet_tuning.sv
`timescale 1ns/1ps
`include "fnet_defs.svh"

// Operation
// - Fractional word is unsigned 24 bits, meaning value over two to 24.
// - Integer division word is an unsigned 19-bit field.
// - Reference clock divided by programmed ratio gives the comparison tick.
// - Output frequency is comparison rate times integer plus fraction.
// - Modulator uses fixed binary modulus of two to the 24.
// - Exact mode keeps full 24-bit accumulator yet gives zero error.
// - Channel mode keeps integer and step fixed, rewrites fraction only.
// - Enable set, bypass clear gives fractional, or exact when step count exceeds one; reverse gives integer.

module fnet_tuning (
	input  wire logic                     core_clk,
	input  wire logic                     rst_n,
	input  wire logic                     reg_wr,
	input  wire logic [`FNET_ADDR_W-1:0]  reg_addr,
	input  wire logic [`FNET_DATA_W-1:0]  reg_wdata,
	input  wire logic                     mod_enable,
	input  wire logic                     mod_bypass,
	output logic      [`FNET_DATA_W-1:0]  reg_rdata,
	output logic                          pd_tick,
	output logic      [`FNET_INT_W-1:0]   div_ratio,
	output fnet_pkg::fnet_mode_t          mode_state
);

	// ****************************************
	// Register file
	// ****************************************
	logic [`FNET_REF_W-1:0]  ref_ratio;
	logic [`FNET_INT_W-1:0]  int_word;
	logic [`FNET_FRAC_W-1:0] frac_word;
	logic [`FNET_STEP_W-1:0] step_count;

	wire wr_ref  = reg_wr && reg_addr == `FNET_OFS_REF_RATIO;
	wire wr_int  = reg_wr && reg_addr == `FNET_OFS_INT_WORD;
	wire wr_frac = reg_wr && reg_addr == `FNET_OFS_FRAC_WORD;
	wire wr_step = reg_wr && reg_addr == `FNET_OFS_STEP_CNT;

	logic [`FNET_DATA_W-1:0] next_rdata;

	always_comb begin
		case (reg_addr)
		`FNET_OFS_REF_RATIO: next_rdata = {10'h000, ref_ratio};
		`FNET_OFS_INT_WORD:  next_rdata = {5'h00, int_word};
		`FNET_OFS_FRAC_WORD: next_rdata = frac_word;
		`FNET_OFS_STEP_CNT:  next_rdata = {10'h000, step_count};
		default:             next_rdata = '0;
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			ref_ratio  <= `FNET_REF_RST;
			int_word   <= `FNET_INT_RST;
			frac_word  <= `FNET_FRAC_RST;
			step_count <= `FNET_STEP_RST;
			reg_rdata  <= '0;
		end else begin
			if (wr_ref)
				ref_ratio <= reg_wdata[`FNET_REF_W-1:0];
			if (wr_int)
				int_word <= reg_wdata[`FNET_INT_W-1:0];
			if (wr_frac)
				frac_word <= reg_wdata;
			if (wr_step)
				step_count <= reg_wdata[`FNET_STEP_W-1:0];
			reg_rdata <= next_rdata;
		end
	end

	// ****************************************
	// Comparison tick
	// ****************************************
	fnet_ref_div u_ref_div (
		.core_clk  (core_clk),
		.rst_n     (rst_n),
		.ref_ratio (ref_ratio),
		.pd_tick   (pd_tick)
	);

	// ****************************************
	// Mode decode
	// ****************************************
	fnet_pkg::fnet_mode_t next_mode;

	// Odd enable/bypass pairs fall back to integer division
	wire frac_on  = mod_enable && !mod_bypass;
	wire exact_on = frac_on && step_count > `FNET_STEP_W'(1);

	assign next_mode = exact_on ? fnet_pkg::FNET_MODE_EXACT :
		frac_on ? fnet_pkg::FNET_MODE_FRAC : fnet_pkg::FNET_MODE_INT;

	// ****************************************
	// Delta-sigma accumulator
	// ****************************************
	logic [`FNET_FRAC_W-1:0] acc;
	logic [`FNET_STEP_W-1:0] step_pos;

	// Rounding excess of the ceiled word over one step period.
	// Taking it back once per period keeps the modulus at 2^24.
	wire [37:0] step_prod = frac_word * step_count;
	wire [`FNET_FRAC_W-1:0] excess = step_prod[`FNET_FRAC_W-1:0];

	wire period_end = exact_on &&
		step_pos == step_count - `FNET_STEP_W'(1);
	wire [25:0] acc_sum = {2'b00, acc} + {2'b00, frac_word} -
		(period_end ? {2'b00, excess} : 26'h0);

	wire [`FNET_INT_W-1:0] next_div = !frac_on ? int_word :
		acc_sum[25] ? int_word - `FNET_INT_W'(1) :
		acc_sum[24] ? int_word + `FNET_INT_W'(1) : int_word;

	wire [`FNET_STEP_W-1:0] next_pos = period_end ? '0 :
		step_pos + `FNET_STEP_W'(1);

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			acc        <= '0;
			step_pos   <= '0;
			div_ratio  <= `FNET_INT_RST;
			mode_state <= fnet_pkg::FNET_MODE_INT;
		end else begin
			mode_state <= next_mode;
			if (wr_frac || wr_step || !exact_on)
				step_pos <= '0;
			else if (pd_tick)
				step_pos <= next_pos;
			if (pd_tick) begin
				div_ratio <= next_div;
				acc       <= frac_on ? acc_sum[`FNET_FRAC_W-1:0] : '0;
			end
		end
	end

	// ****************************************
	// Checks
	// ****************************************
	logic [`FNET_REF_W:0]    gap;
	logic [`FNET_FRAC_W-1:0] acc_start;
	logic                    have_start;
	logic                    tick_seen;

	// First tick after a ratio change may come early; skip its spacing
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			gap        <= '0;
			acc_start  <= '0;
			have_start <= 1'b0;
			tick_seen  <= 1'b0;
		end else begin
			gap <= pd_tick || wr_ref ? '0 : gap + (`FNET_REF_W+1)'(1);
			if (wr_ref)
				tick_seen <= 1'b0;
			else if (pd_tick)
				tick_seen <= 1'b1;
			if (wr_frac || wr_step || !exact_on || !frac_on)
				have_start <= 1'b0;
			else if (pd_tick && step_pos == '0) begin
				acc_start  <= acc;
				have_start <= 1'b1;
			end
		end
	end

	sequence s_frac_write;
		wr_frac ##1 !reg_wr;
	endsequence

	property p_frac_readback;
		@(posedge core_clk) disable iff (!rst_n)
		s_frac_write ##0 reg_addr == `FNET_OFS_FRAC_WORD
			|=> reg_rdata == $past(reg_wdata, 2);
	endproperty
	a_frac_readback: assert property (p_frac_readback)
		else $error("fractional word readback wrong");

	property p_int_width;
		@(posedge core_clk) disable iff (!rst_n)
		reg_addr == `FNET_OFS_INT_WORD |=> reg_rdata[23:19] == 5'h00;
	endproperty
	a_int_width: assert property (p_int_width)
		else $error("integer word readback too wide");

	property p_tick_gap;
		@(posedge core_clk) disable iff (!rst_n)
		pd_tick && $past(pd_tick) == 1'b0 && ref_ratio > 14'h0001 &&
			$stable(ref_ratio) && gap > '0 && tick_seen
			|-> gap == {1'b0, ref_ratio} - 15'h0001;
	endproperty
	a_tick_gap: assert property (p_tick_gap)
		else $error("comparison tick spacing wrong");

	property p_int_div;
		@(posedge core_clk) disable iff (!rst_n)
		pd_tick && !frac_on |=> div_ratio == $past(int_word);
	endproperty
	a_int_div: assert property (p_int_div)
		else $error("integer mode ratio wrong");

	property p_frac_div;
		@(posedge core_clk) disable iff (!rst_n)
		pd_tick && frac_on && !exact_on |=>
			div_ratio == $past(int_word) ||
			div_ratio == $past(int_word) + 19'h00001;
	endproperty
	a_frac_div: assert property (p_frac_div)
		else $error("fractional ratio out of range");

	property p_exact_repeat;
		@(posedge core_clk) disable iff (!rst_n)
		pd_tick && period_end && have_start && !reg_wr
			|=> acc == acc_start;
	endproperty
	a_exact_repeat: assert property (p_exact_repeat)
		else $error("exact period did not close");

	property p_channel_keep;
		@(posedge core_clk) disable iff (!rst_n)
		wr_frac |=> $stable(int_word) && $stable(step_count) &&
			frac_word == $past(reg_wdata);
	endproperty
	a_channel_keep: assert property (p_channel_keep)
		else $error("fraction write disturbed other words");

	property p_mode;
		@(posedge core_clk) disable iff (!rst_n)
		mod_enable && !mod_bypass ##1 1'b1 |->
			mode_state != fnet_pkg::FNET_MODE_INT;
	endproperty
	a_mode: assert property (p_mode)
		else $error("mode decode wrong");

	property p_frac_restart;
		@(posedge core_clk) disable iff (!rst_n)
		wr_frac |=> step_pos == '0;
	endproperty
	a_frac_restart: assert property (p_frac_restart)
		else $error("new fraction did not restart period");

endmodule

//--- dv/fnet_tuning_tb.sv
`timescale 1ns/1ps
`include "fnet_defs.svh"

module fnet_tuning_tb;
	logic                    core_clk;
	logic                    rst_n;
	logic                    reg_wr;
	logic [`FNET_ADDR_W-1:0] reg_addr;
	logic [`FNET_DATA_W-1:0] reg_wdata;
	logic                    mod_enable;
	logic                    mod_bypass;
	logic [`FNET_DATA_W-1:0] reg_rdata;
	logic                    pd_tick;
	logic [`FNET_INT_W-1:0]  div_ratio;
	fnet_pkg::fnet_mode_t    mode_state;
	int                      errors;
	int                      comparisons;
	int                      m_reg[int];
	logic [31:0]             ratio_q[$];
	logic                    tick_d;
	int                      gap;
	int                      since;
	int                      tick_cnt;
	int                      adr[6] = '{2, 3, 4, 12, 5, 6};
	int                      stp[2] = '{0, 10};
	int                      frc[2] = '{1048576, 1677722};
	int                      per[2] = '{16, 10};

	fnet_tuning i_dut (
		.core_clk   (core_clk),
		.rst_n      (rst_n),
		.reg_wr     (reg_wr),
		.reg_addr   (reg_addr),
		.reg_wdata  (reg_wdata),
		.mod_enable (mod_enable),
		.mod_bypass (mod_bypass),
		.reg_rdata  (reg_rdata),
		.pd_tick    (pd_tick),
		.div_ratio  (div_ratio),
		.mode_state (mode_state)
	);

	initial begin
		core_clk = 1'b0;
		forever #50 core_clk = ~core_clk;
	end

	// ****
	// Tick monitor: ratio is valid the cycle after its tick
	// ****
	always @(posedge core_clk) begin
		if (tick_d === 1'b1)
			ratio_q.push_back(div_ratio);
		tick_d = pd_tick;
		if (pd_tick === 1'b1) begin
			gap = since;
			since = 1;
			tick_cnt++;
		end else
			since++;
	end

	task chk(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			errors++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task stop_test;
		$display("errors=%0d comparisons=%0d", errors, comparisons);
		if (errors == 0 && comparisons > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	function int wid(input int a);
		case (a)
			2, 12: return 14;
			3: return 19;
			4: return 24;
			default: return 0;
		endcase
	endfunction

	function fnet_pkg::fnet_mode_t exp_mode(input logic en, input logic bp);
		if (en && !bp)
			return (m_reg[12] >= 2) ? fnet_pkg::FNET_MODE_EXACT
				: fnet_pkg::FNET_MODE_FRAC;
		return fnet_pkg::FNET_MODE_INT;
	endfunction

	// Whole periods only: any full period sums the same
	function logic [31:0] exp_sum(input int p);
		longint f;
		f = (longint'(m_reg[4]) * p) >> 24;
		if (exp_mode(mod_enable, mod_bypass) == fnet_pkg::FNET_MODE_INT)
			f = 0;
		return p * m_reg[3] + f;
	endfunction

	task wr(input int a, input int d);
		@(posedge core_clk);
		reg_wr <= 1'b1;
		reg_addr <= a[4:0];
		reg_wdata <= d[23:0];
		if (wid(a) > 0)
			m_reg[a] = d & ((1 << wid(a)) - 1);
	endtask

	task idle;
		@(posedge core_clk);
		reg_wr <= 1'b0;
	endtask

	task rd(input int a);
		@(posedge core_clk);
		reg_addr <= a[4:0];
		@(posedge core_clk);
		@(negedge core_clk);
		chk(reg_rdata, m_reg.exists(a) ? m_reg[a] : 0);
	endtask

	task ratio_sum(input int p);
		int n;
		logic [31:0] s;
		s = 0;
		n = 0;
		ratio_q.delete();
		while (ratio_q.size() < 2 * p && n < 1000) begin
			@(posedge core_clk);
			n++;
		end
		if (n >= 1000) begin
			chk(1, 0);
			stop_test();
		end
		for (int i = p; i < 2 * p; i++)
			s += ratio_q[i];
		chk(s, exp_sum(p));
	endtask

	initial begin
		{reg_wr, reg_addr, reg_wdata, mod_enable, mod_bypass} = '0;
		rst_n = 1'b0;
		m_reg[2] = 1;
		m_reg[3] = 20;
		m_reg[4] = 0;
		m_reg[12] = 0;
		void'($urandom(62));
		repeat (6) @(posedge core_clk);
		rst_n <= 1'b1;
		@(negedge core_clk);
		chk(div_ratio, 20);
		chk(mode_state, fnet_pkg::FNET_MODE_INT);
		foreach (adr[i]) rd(adr[i]);
		$display("test reset done");
		// Back to back, oversize data, unmapped places
		foreach (adr[i]) wr(adr[i], $urandom);
		idle();
		foreach (adr[i]) rd(adr[i]);
		$display("test regs done");
		foreach (adr[i]) begin
			if (i < 4) begin
				wr(2, i * 2 + i / 2);
				idle();
				tick_cnt = 0;
				for (int k = 0; k < 1000 && tick_cnt < 3; k++)
					@(posedge core_clk);
				if (tick_cnt < 3) begin
					chk(1, 0);
					stop_test();
				end
				chk(gap, (i == 0) ? 1 : i * 2 + i / 2);
			end
		end
		$display("test ref done");
		wr(2, 1);
		wr(3, 20 + $urandom % 524265);
		foreach (stp[j]) begin
			wr(12, stp[j]);
			wr(4, frc[j]);
			idle();
			for (int m = 0; m < 4; m++) begin
				@(posedge core_clk);
				mod_enable <= m[1];
				mod_bypass <= m[0];
				repeat (3) @(posedge core_clk);
				@(negedge core_clk);
				chk(mode_state, exp_mode(m[1], m[0]));
				ratio_sum(per[j]);
			end
		end
		$display("test modes done");
		// Channel steps: only the fractional word moves
		@(posedge core_clk);
		mod_enable <= 1'b1;
		mod_bypass <= 1'b0;
		wr(3, m_reg[3]);
		wr(12, 10);
		for (int k = 1; k < 4; k++) begin
			wr(4, $urandom);
			wr(4, (k * 16777216 + 9) / 10);
			idle();
			ratio_sum(10);
		end
		$display("test channel done");
		stop_test();
	end
endmodule
